// ===== rtl/tap_pkg.sv
// Package with constants and types shared by the test port ends
package tap_pkg;
   // ***************************************************
   // Controller states
   // ***************************************************
   typedef enum logic [3:0]
   {
      ST_RESET,
      ST_IDLE,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPD_IR
   } tap_state_e;

   // ***************************************************
   // Instruction chain and codes
   // ***************************************************
   localparam int          IR_WIDTH      = 4;
   localparam logic [3:0]  IR_CAPTURE    = 4'h1;
   localparam logic [3:0]  OP_EXTEST     = 4'h0;
   localparam logic [3:0]  OP_INTEST     = 4'h1;
   localparam logic [3:0]  OP_SAMPLE     = 4'h2;
   localparam logic [3:0]  OP_CORE_A     = 4'h8;
   localparam logic [3:0]  OP_CORE_B     = 4'hA;
   localparam logic [3:0]  OP_CORE_C     = 4'hB;
   localparam logic [3:0]  OP_IDCODE     = 4'hE;
   localparam logic [3:0]  OP_BYPASS     = 4'hF;
   localparam logic [3:0]  IR_RESET      = OP_IDCODE;

   // ***************************************************
   // Data chains
   // ***************************************************
   localparam int          ID_WIDTH      = 32;
   localparam logic [31:0] ID_VALUE      = 32'h1234_5677; // Arbitrary value
   localparam int          BS_WIDTH      = 8;
   localparam logic [7:0]  BS_RESET      = 8'h00;
   localparam logic [7:0]  HOLD_RESET    = 8'h00;

   // ***************************************************
   // Timing and counts
   // ***************************************************
   localparam int          RESET_TMS_CNT = 5;
   localparam int          SYNC_STAGES   = 3;
   localparam int          TCK_DIV       = 4;
   localparam logic [7:0]  TCK_DIV_W     = 8'h04;
endpackage : tap_pkg

// ===== rtl/tap_link_if.sv
// Interface carrying the four test port pins between the two ends
`timescale 1ns/1ps
interface tap_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo_o;
   logic tdo_oe;
   logic tdo;

   // Pull-up resolves the undriven data output
   assign tdo = tdo_oe ? tdo_o : 1'b1;

   modport device
   (
      input  tck,
      input  tms,
      input  tdi,
      output tdo_o,
      output tdo_oe
   );

   modport tester
   (
      output tck,
      output tms,
      output tdi,
      input  tdo
   );
endinterface : tap_link_if

// ===== rtl/tap_device.sv
// Test access port controller with instruction and data chains
`timescale 1ns/1ps
module tap_device
#(
   parameter int BS_W = tap_pkg::BS_WIDTH
)
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             pin_rst,
   tap_link_if.device            link,
   input  wire logic [BS_W-1:0]  pin_sample,
   output logic      [BS_W-1:0]  bs_hold,
   output logic                  test_mode,
   output logic                  core_sel,
   input  wire logic             core_tdo,
   output logic                  core_shift,
   output logic                  core_tdi,
   output logic      [3:0]       ir_out,
   output logic                  pull_up_q,
   output logic                  pull_down_q
);
   // Widths the shift logic cannot serve
   if (BS_W < 2 || BS_W > 64)
      $error("BS_W out of range");

   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   logic [2:0]                 tck_s_q;
   logic [2:0]                 tms_s_q;
   logic [2:0]                 tdi_s_q;
   logic                       tck_v_q;
   logic                       tms_v_q;
   logic                       tdi_v_q;
   logic                       tms_v;
   logic                       tdi_v;
   logic                       rise;
   logic                       fall;

   // Three stages; change counts once stages two and three agree
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tck_s_q <= 3'h0;
         tms_s_q <= 3'h7;
         tdi_s_q <= 3'h7;
         tck_v_q <= 1'b0;
         tms_v_q <= 1'b1;
         tdi_v_q <= 1'b1;
      end
      else
      begin
         tck_s_q <= {tck_s_q[1:0], link.tck};
         tms_s_q <= {tms_s_q[1:0], link.tms};
         tdi_s_q <= {tdi_s_q[1:0], link.tdi};
         if (tck_s_q[1] == tck_s_q[2])
            tck_v_q <= tck_s_q[2];
         if (tms_s_q[1] == tms_s_q[2])
            tms_v_q <= tms_s_q[2];
         if (tdi_s_q[1] == tdi_s_q[2])
            tdi_v_q <= tdi_s_q[2];
      end
   end

   assign rise  = (tck_s_q[1] == tck_s_q[2]) && tck_s_q[2] && !tck_v_q;
   assign fall  = (tck_s_q[1] == tck_s_q[2]) && !tck_s_q[2] && tck_v_q;
   assign tms_v = tms_v_q;
   assign tdi_v = tdi_v_q;

   // ***************************************************
   // Controller state machine
   // ***************************************************
   tap_pkg::tap_state_e state_q;
   tap_pkg::tap_state_e state_d;

   // Standard transitions on sampled mode select
   always_comb
   begin
      case (state_q)
         tap_pkg::ST_RESET:    state_d = tms_v ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
         tap_pkg::ST_IDLE:     state_d = tms_v ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_DR:   state_d = tms_v ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
         tap_pkg::ST_CAP_DR:   state_d = tms_v ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_SHIFT_DR: state_d = tms_v ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_EXIT1_DR: state_d = tms_v ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_PAUSE_DR: state_d = tms_v ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_EXIT2_DR: state_d = tms_v ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_UPD_DR:   state_d = tms_v ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_IR:   state_d = tms_v ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
         tap_pkg::ST_CAP_IR:   state_d = tms_v ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_SHIFT_IR: state_d = tms_v ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_EXIT1_IR: state_d = tms_v ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_PAUSE_IR: state_d = tms_v ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_EXIT2_IR: state_d = tms_v ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_UPD_IR:   state_d = tms_v ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         default:              state_d = tap_pkg::ST_RESET;
      endcase
   end

   // State register; only moves on a clock rise
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         state_q <= tap_pkg::ST_RESET;
      else if (rise)
         state_q <= state_d;
   end

   // ***************************************************
   // Instruction decode
   // ***************************************************
   logic [3:0] ir_sh_q;
   logic [3:0] ir_q;
   logic [3:0] op;
   logic       is_core;

   // Map unimplemented codes to bypass
   function automatic logic [3:0] decode(input logic [3:0] code);
      case (code)
         tap_pkg::OP_EXTEST, tap_pkg::OP_INTEST, tap_pkg::OP_SAMPLE,
         tap_pkg::OP_CORE_A, tap_pkg::OP_CORE_B, tap_pkg::OP_CORE_C,
         tap_pkg::OP_IDCODE: decode = code;
         default:            decode = tap_pkg::OP_BYPASS;
      endcase
   endfunction : decode

   assign op        = decode(ir_q);
   assign is_core   = op inside {tap_pkg::OP_CORE_A, tap_pkg::OP_CORE_B, tap_pkg::OP_CORE_C};
   assign test_mode = (op == tap_pkg::OP_EXTEST) || (op == tap_pkg::OP_INTEST);
   assign ir_out    = ir_q;

   // ***************************************************
   // Chains
   // ***************************************************
   logic [31:0]     id_sh_q;
   logic [BS_W-1:0] bs_sh_q;
   logic            byp_q;
   logic            tdo_d;
   logic            tdo_q;
   logic            oe_q;
   logic            shifting;

   // Instruction chain, four bits with hold register
   always_ff @(posedge clk_sys)
   begin
      if (rst || (rise && state_d == tap_pkg::ST_RESET))
      begin
         ir_sh_q <= tap_pkg::IR_CAPTURE;
         ir_q    <= tap_pkg::IR_RESET;
      end
      else if (rise)
      begin
         case (state_q)
            tap_pkg::ST_CAP_IR:   ir_sh_q <= tap_pkg::IR_CAPTURE;
            tap_pkg::ST_SHIFT_IR: ir_sh_q <= {tdi_v, ir_sh_q[3:1]};
            tap_pkg::ST_UPD_IR:   ir_q    <= ir_sh_q;
            default:              ir_q    <= ir_q;
         endcase
      end
   end

   // Data chains; external and internal test leave them alone
   always_ff @(posedge clk_sys)
   begin
      if (rst || (rise && state_d == tap_pkg::ST_RESET))
      begin
         id_sh_q <= tap_pkg::ID_VALUE;
         bs_sh_q <= BS_W'(tap_pkg::BS_RESET);
         bs_hold <= BS_W'(tap_pkg::HOLD_RESET);
         byp_q   <= 1'b0;
      end
      else if (rise && !test_mode)
      begin
         case (state_q)
            tap_pkg::ST_CAP_DR:
            begin
               id_sh_q <= tap_pkg::ID_VALUE;
               bs_sh_q <= pin_sample;
               byp_q   <= 1'b0;
            end
            tap_pkg::ST_SHIFT_DR:
            begin
               if (op == tap_pkg::OP_IDCODE)
                  id_sh_q <= {tdi_v, id_sh_q[31:1]};
               else if (op == tap_pkg::OP_SAMPLE)
                  bs_sh_q <= {tdi_v, bs_sh_q[BS_W-1:1]};
               else
                  byp_q <= tdi_v;
            end
            tap_pkg::ST_UPD_DR:
            begin
               if (op == tap_pkg::OP_SAMPLE)
                  bs_hold <= bs_sh_q;
            end
            default: byp_q <= byp_q;
         endcase
      end
   end

   // Core controller shares the shift path
   assign core_sel   = is_core;
   assign core_shift = is_core && state_q == tap_pkg::ST_SHIFT_DR;
   assign core_tdi   = tdi_v;

   // ***************************************************
   // Serial output
   // ***************************************************
   assign shifting = (state_q == tap_pkg::ST_SHIFT_DR && !test_mode)
                     || state_q == tap_pkg::ST_SHIFT_IR;

   // Output source by state and instruction
   always_comb
   begin
      if (state_q == tap_pkg::ST_SHIFT_IR)
         tdo_d = ir_sh_q[0];
      else if (is_core)
         tdo_d = core_tdo;
      else if (op == tap_pkg::OP_IDCODE)
         tdo_d = id_sh_q[0];
      else if (op == tap_pkg::OP_SAMPLE)
         tdo_d = bs_sh_q[0];
      else
         tdo_d = byp_q;
   end

   // Output and enable move on the falling clock
   always_ff @(posedge clk_sys)
   begin
      if (rst || pin_rst)
      begin
         tdo_q <= 1'b1;
         oe_q  <= 1'b0;
      end
      else if (fall)
      begin
         tdo_q <= tdo_d;
         oe_q  <= shifting;
      end
   end

   assign link.tdo_o  = tdo_q;
   assign link.tdo_oe = oe_q;

   // Pad pulls restored by either reset
   always_ff @(posedge clk_sys)
   begin
      if (rst || pin_rst)
      begin
         pull_up_q   <= 1'b1;
         pull_down_q <= 1'b0;
      end
   end
endmodule : tap_device

// ===== rtl/tap_tester.sv
// Tester end: drives clock, mode select and data, captures output
`timescale 1ns/1ps
module tap_tester
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   tap_link_if.tester       link,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_tms,
   input  wire logic        req_tdi,
   output logic             rsp_valid,
   output logic             rsp_tdo
);
   // ***************************************************
   // One test clock cycle per request
   // ***************************************************
   logic [7:0] div_q;
   logic       busy_q;
   logic       tck_q;
   logic       tms_q;
   logic       tdi_q;
   logic [2:0] tdo_s_q;

   assign req_ready = !busy_q;

   // Half-period divider; clock rises mid cycle, falls at end
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         div_q     <= 8'h00;
         busy_q    <= 1'b0;
         tck_q     <= 1'b0;
         tms_q     <= 1'b1;
         tdi_q     <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_tdo   <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (!busy_q && req_valid)
         begin
            busy_q <= 1'b1;
            tms_q  <= req_tms;
            tdi_q  <= req_tdi;
            div_q  <= 8'h00;
         end
         else if (busy_q)
         begin
            div_q <= div_q + 8'h01;
            if (div_q == tap_pkg::TCK_DIV_W - 8'h01)
            begin
               tck_q   <= 1'b1;
            end
            else if (div_q == 8'(2 * tap_pkg::TCK_DIV) - 8'h01)
            begin
               // Taken at end of high phase; device pin path lags the fall
               rsp_tdo   <= tdo_s_q[2];
               tck_q     <= 1'b0;
               busy_q    <= 1'b0;
               rsp_valid <= 1'b1;
            end
         end
      end
   end

   // Output from the device synchronised
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         tdo_s_q <= 3'h7;
      else
         tdo_s_q <= {tdo_s_q[1:0], link.tdo};
   end

   assign link.tck = tck_q;
   assign link.tms = tms_q;
   assign link.tdi = tdi_q;
endmodule : tap_tester

// ===== bench/tap_props.sv
// Checker for the test port link between the two ends
`timescale 1ns/1ps
module tap_props
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo_o,
   input wire logic tdo_oe,
   input wire logic tdo
);
   // ***************************************************
   // Link history
   // ***************************************************
   logic       tck_q;
   logic       tms_q;
   logic [2:0] fall_q;
   logic [2:0] high_q;
   logic [1:0] rise_q;
   wire        rise = tck && !tck_q;

   // Cycles since the last clock fall
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tck_q  <= 1'b0;
         fall_q <= 3'h7;
      end
      else
      begin
         tck_q <= tck;
         if (tck_q && !tck)
            fall_q <= 3'h0;
         else if (fall_q != 3'h7)
            fall_q <= fall_q + 3'h1;
      end
   end

   // Mode select at each rise, run of highs, rises since reset
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tms_q  <= 1'b1;
         high_q <= 3'h0;
         rise_q <= 2'h0;
      end
      else if (rise)
      begin
         tms_q  <= tms;
         high_q <= !tms ? 3'h0 : (high_q == 3'h5) ? high_q : high_q + 3'h1;
         rise_q <= (rise_q == 2'h3) ? rise_q : rise_q + 2'h1;
      end
   end

   // ***************************************************
   // Properties
   // ***************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   edge_only_a: assert property ($changed(tdo_oe) |-> fall_q <= 3'h4)
      else $error("output enable moved away from a clock fall");
   clock_hold_a: assert property ($stable(tck)[*8] |-> $stable(tdo_oe)
      && (!tdo_oe || $stable(tdo_o)))
      else $error("output moved while the clock stood");
   pull_up_a: assert property (!tdo_oe |-> tdo)
      else $error("released output not pulled high");
   tms_reset_a: assert property (high_q == 3'h5 |-> !tdo_oe)
      else $error("output driven after five high mode selects");
   shift_enter_a: assert property ($rose(tdo_oe) |-> !tms_q)
      else $error("output driven without a low mode select");
   shift_leave_a: assert property ($fell(tdo_oe) |-> tms_q)
      else $error("output released inside a shift");
   exit_quiet_a: assert property (!tck && fall_q == 3'h4 && tms_q |-> !tdo_oe)
      else $error("output still driven after leaving a shift");
   reset_quiet_a: assert property (rise_q != 2'h3 |-> !tdo_oe)
      else $error("output driven too soon after power-on reset");
   tms_fall_a: assert property ($changed(tms) |-> !tck)
      else $error("mode select moved while the clock was high");
   tdi_fall_a: assert property ($changed(tdi) |-> !tck)
      else $error("data input moved while the clock was high");
   duty_high_a: assert property ($rose(tck) |-> tck[*4] ##1 !tck)
      else $error("clock high time not four cycles");
   duty_low_a: assert property ($fell(tck) |-> !tck[*4])
      else $error("clock low time under four cycles");
endmodule : tap_props

// ===== bench/test_jtag_tap_shift_chains.sv
// Bench joining the tester end to the device end
`timescale 1ns/1ps
module test_jtag_tap_shift_chains;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        pin_rst = 1'b0;
   logic [7:0]  pin_sample = 8'h00;
   logic [7:0]  bs_hold;
   logic        test_mode;
   logic        core_sel;
   logic        core_tdo = 1'b0;
   logic [3:0]  ir_out;
   logic        pull_up_q;
   logic        pull_down_q;
   logic        req_valid = 1'b0;
   logic        req_ready;
   logic        req_tms = 1'b1;
   logic        req_tdi = 1'b1;
   logic        rsp_valid;
   logic        rsp_tdo;
   logic [31:0] d;
   int          n_errors = 0;
   int          cmp_count = 0;

   // Clock at 250 MHz
   always #2 clk_sys = ~clk_sys;

   tap_link_if link_if();

   tap_device u_tap_device
   (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .pin_rst     (pin_rst),
      .link        (link_if),
      .pin_sample  (pin_sample),
      .bs_hold     (bs_hold),
      .test_mode   (test_mode),
      .core_sel    (core_sel),
      .core_tdo    (core_tdo),
      .core_shift  (),
      .core_tdi    (),
      .ir_out      (ir_out),
      .pull_up_q   (pull_up_q),
      .pull_down_q (pull_down_q)
   );

   tap_tester u_tap_tester
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .link      (link_if),
      .req_valid (req_valid),
      .req_ready (req_ready),
      .req_tms   (req_tms),
      .req_tdi   (req_tdi),
      .rsp_valid (rsp_valid),
      .rsp_tdo   (rsp_tdo)
   );

   tap_props u_tap_props
   (
      .clk_sys (clk_sys),
      .rst     (rst),
      .tck     (link_if.tck),
      .tms     (link_if.tms),
      .tdi     (link_if.tdi),
      .tdo_o   (link_if.tdo_o),
      .tdo_oe  (link_if.tdo_oe),
      .tdo     (link_if.tdo)
   );

   // ***************************************************
   // Tasks
   // ***************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One test clock period through the request handshake
   task automatic bit_io(input logic m, input logic i, output logic o);
      int n;
      @(negedge clk_sys);
      req_valid = 1'b1;
      req_tms = m;
      req_tdi = i;
      for (n = 0; n < 40 && req_ready !== 1'b1; n++)
         @(negedge clk_sys);
      if (n == 40)
         n_errors++;
      @(negedge clk_sys);
      req_valid = 1'b0;
      for (n = 0; n < 40 && rsp_valid !== 1'b1; n++)
         @(negedge clk_sys);
      if (n == 40)
         n_errors++;
      o = rsp_tdo;
   endtask : bit_io

   // Mode select path, first bit first
   task automatic walk(input logic [7:0] path, input int n);
      logic o;
      for (int k = 0; k < n; k++)
         bit_io(path[k], 1'b1, o);
   endtask : walk

   // Capture, shift n bits, update, back to idle
   task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] q);
      logic o;
      q = 32'h0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int k = 0; k < n; k++)
      begin
         bit_io(k == n - 1, din[k], o);
         q[k] = o;
      end
      walk(8'h01, 2);
   endtask : scan

   // ***************************************************
   // Tests
   // ***************************************************
   task automatic test_start;
      check("pull_up", 32'(pull_up_q), 32'h1);
      check("pull_down", 32'(pull_down_q), 32'h0);
      check("ir_out", 32'(ir_out), 32'(tap_pkg::IR_RESET));
      check("tdo idle", 32'(link_if.tdo), 32'h1);
      walk(8'h1F, 6);
      scan(1'b0, 32'h0, 32, d);
      check("idcode", d, tap_pkg::ID_VALUE);
      $display("test_start done");
   endtask : test_start

   // Sample chain, pin reset, stopped clock, reset from a shift
   task automatic test_sample;
      pin_sample = 8'hA5;
      scan(1'b1, 32'(tap_pkg::OP_SAMPLE), 4, d);
      check("ir capture", d, 32'(tap_pkg::IR_CAPTURE));
      check("ir_out", 32'(ir_out), 32'(tap_pkg::OP_SAMPLE));
      scan(1'b0, 32'h3C, 8, d);
      check("sample out", d, 32'hA5);
      check("bs_hold", 32'(bs_hold), 32'h3C);
      pin_rst = 1'b1;
      repeat (4) @(negedge clk_sys);
      pin_rst = 1'b0;
      repeat (200) @(negedge clk_sys);
      check("ir kept", 32'(ir_out), 32'(tap_pkg::OP_SAMPLE));
      check("hold kept", 32'(bs_hold), 32'h3C);
      check("pull_down", 32'(pull_down_q), 32'h0);
      walk(8'h01, 3);
      walk(8'h1F, 5);
      check("ir reset", 32'(ir_out), 32'(tap_pkg::IR_RESET));
      check("hold reset", 32'(bs_hold), 32'(tap_pkg::HOLD_RESET));
      walk(8'h00, 1);
      $display("test_sample done");
   endtask : test_sample

   // Every code: decode flags; data out checked and hold register untouched for all but sample
   task automatic test_codes;
      logic [7:0] keep;
      logic [7:0] exp;
      logic       core;
      for (int c = 0; c < 16; c++)
      begin
         keep = bs_hold;
         core = 4'(c) inside {tap_pkg::OP_CORE_A, tap_pkg::OP_CORE_B, tap_pkg::OP_CORE_C};
         scan(1'b1, 32'(c), 4, d);
         check("ir_out", 32'(ir_out), 32'(c));
         check("test_mode", 32'(test_mode), 32'(c < 2));
         check("core_sel", 32'(core_sel), 32'(core));
         if (c == 2)
            continue;
         exp = (c < 2) ? 8'hFF : core ? 8'h00 : (c == 14) ? tap_pkg::ID_VALUE[7:0] : 8'h68;
         scan(1'b0, 32'hB4, 8, d);
         check("dr out", d, 32'(exp));
         check("hold kept", 32'(bs_hold), 32'(keep));
      end
      $display("test_codes done");
   endtask : test_codes

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   // Main sequence
   initial
   begin
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      test_start();
      test_sample();
      test_codes();
      final_report();
   end

   // Watchdog well beyond the expected run of about 4500 cycles
   initial
   begin
      repeat (30000) @(posedge clk_sys);
      n_errors++;
      final_report();
   end
endmodule : test_jtag_tap_shift_chains
